/* File: hw/ctir_regs.sv */
// control and status registers for converter/transmitter flags and receiver setup
// assumes a host serial front end turning frames into single-cycle register strobes
// condition, clock and lock inputs come from other domains and are synchronised here
`timescale 1ns/1ps
`include "ctir_params.svh"

// Behaviour
// R01 - buffer-copy flag sets on completed copy while copies enabled and unmasked
// R02 - copy or slip flag drives interrupt low and sets transmitter summary
// R03 - slip flag sets on data slip or block start while unmasked
// R04 - slip source select input picks data slip or block start
// R05 - ready flag sets when both rate estimators finish fast phase, if unmasked
// R06 - ratio flag sets when input rate exceeds output rate, if unmasked
// R07 - ready or ratio flag drives interrupt low and sets converter summary
// R08 - mask register bits 5,4,1,0 enable flags; zero masks, reset zero
// R09 - trigger register two bits per flag: rise, fall, level, reserved
// R10 - status register read only; bits 7,6,3,2 read zero
// R11 - input select routes line receiver one to four into receiver core
// R12 - reference select feeds first loop from receiver input or master clock
// R13 - receiver copy disable freezes receive-to-user buffer updates
// R14 - recovered clock pin enable: zero floats pin, one drives clock
// R15 - divider code divides second loop clock by 1, 2, 4 or 8
// R16 - auto-mute forces audio low when decoder and second loop lose lock
// R17 - lock-loss mode stops or free-runs second loop clock on loss
// R18 - transmitter copy disable blocks user-to-transmit buffer copies
// R19 - edge modes latch, level follows, latched flags clear on status read
// R20 - host must not program reserved trigger code
module ctir_regs #(
	parameter int AUDIO_W = 24
) (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_rvalid_o,
	input wire ctir_pkg::ctir_cond_t cond_i,
	input wire logic tx_copy_disable_i,
	input wire logic slip_source_select_i,
	output logic tx_copy_enable_o,
	output logic irq_n_o,
	output logic tx_summary_o,
	output logic conv_summary_o,
	input wire logic [3:0] line_rx_i,
	output logic rx_core_data_o,
	input wire logic receiver_reference_input_i,
	input wire logic master_clock_i,
	output logic receiver_first_loop_ref_o,
	output logic receiver_copy_enable_o,
	input wire logic second_loop_clk_i,
	input wire ctir_pkg::ctir_lock_t lock_i,
	output logic recovered_clock_o,
	output logic recovered_clock_oe_o,
	output logic recovered_clock_int_o,
	input wire logic [AUDIO_W-1:0] audio_data_i,
	output logic [AUDIO_W-1:0] audio_data_o
);
	if (AUDIO_W < 1 || AUDIO_W > 32) begin : g_bad_width
		$error("AUDIO_W must lie in 1..32");
	end

	logic [`CTIR_SYNC_W-1:0] sync_a_reg;
	logic [`CTIR_SYNC_W-1:0] sync_b_reg;
	logic [`CTIR_SYNC_W-1:0] async_in;
	logic [7:0] mask_reg;
	logic [7:0] mode_reg;
	logic [7:0] rx_one_reg;
	logic [7:0] rx_two_reg;
	logic [7:0] reg_rdata_reg;
	logic [7:0] status_word;
	logic [7:0] rdata_next;
	logic reg_rvalid_reg;
	logic [3:0] flags;
	logic [3:0] flag_cond;
	logic [3:0] flag_mask;
	logic status_clear;
	logic irq_n_reg;
	logic tx_summary_reg;
	logic conv_summary_reg;
	logic s_copy_done;
	logic s_slip;
	logic s_block_start;
	logic s_ready;
	logic s_ratio;
	logic [3:0] s_line_rx;
	logic s_ref_input;
	logic s_master_clk;
	logic s_loop_clk;
	logic s_dec_lost;
	logic s_loop_lost;
	logic loop_clk_prev_reg;
	logic [2:0] div_cnt_reg;
	logic div_clk;
	logic clk_stopped;
	logic rec_clk_reg;
	logic rec_clk_oe_reg;
	logic rx_core_reg;
	logic first_ref_reg;
	logic [AUDIO_W-1:0] audio_reg;
	logic both_lost;

	// every foreign input passes two flops before any logic sees it
	assign async_in = {lock_i.second_loop_lock_loss, lock_i.decoder_lock_loss,
		second_loop_clk_i, master_clock_i, receiver_reference_input_i, line_rx_i,
		cond_i.conv_ratio, cond_i.conv_ready, cond_i.tx_block_start,
		cond_i.tx_data_slip, cond_i.tx_copy_done};
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sync_a_reg <= '0;
			sync_b_reg <= '0;
		end else begin
			sync_a_reg <= async_in;
			sync_b_reg <= sync_a_reg;
		end
	end

	assign s_copy_done = sync_b_reg[0];
	assign s_slip = sync_b_reg[1];
	assign s_block_start = sync_b_reg[2];
	assign s_ready = sync_b_reg[3];
	assign s_ratio = sync_b_reg[4];
	assign s_line_rx = sync_b_reg[8:5];
	assign s_ref_input = sync_b_reg[9];
	assign s_master_clk = sync_b_reg[10];
	assign s_loop_clk = sync_b_reg[11];
	assign s_dec_lost = sync_b_reg[12];
	assign s_loop_lost = sync_b_reg[13];
	// host writes; the status word has no storage behind a write
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			mask_reg <= `CTIR_RST_MASK;
			mode_reg <= `CTIR_RST_MODE;
			rx_one_reg <= `CTIR_RST_RX_ONE;
			rx_two_reg <= `CTIR_RST_RX_TWO;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				`CTIR_ADDR_MASK: mask_reg <= reg_wdata_i & `CTIR_MASK_WMASK; // [R08]
				`CTIR_ADDR_MODE: mode_reg <= reg_wdata_i; // [R09]
				`CTIR_ADDR_RX_ONE: rx_one_reg <= reg_wdata_i & `CTIR_RX_ONE_WMASK;
				`CTIR_ADDR_RX_TWO: rx_two_reg <= reg_wdata_i & `CTIR_RX_TWO_WMASK;
				default: mask_reg <= mask_reg; // [R10]
			endcase
		end
	end

	// flag order in the cell array: copy, slip, ready, ratio
	assign tx_copy_enable_o = ~tx_copy_disable_i; // [R18]
	assign flag_cond[0] = s_copy_done & ~tx_copy_disable_i; // [R01] [R18]
	assign flag_cond[1] = slip_source_select_i ? s_block_start : s_slip; // [R03] [R04]
	assign flag_cond[2] = s_ready; // [R05]
	assign flag_cond[3] = s_ratio; // [R06]
	assign flag_mask = {mask_reg[`CTIR_BIT_RATIO], mask_reg[`CTIR_BIT_READY],
		mask_reg[`CTIR_BIT_SLIP], mask_reg[`CTIR_BIT_COPY]};
	assign status_clear = reg_rd_i && (reg_addr_i == `CTIR_ADDR_STATUS); // [R19]
	// reserved code 11 raises nothing; the host is trusted to avoid it [R20]
	for (genvar gi = 0; gi < 4; gi++) begin : g_flag
		ctir_flag_cell u_cell (
			.clk_sys_i(clk_sys_i),
			.resetn_i(resetn_i),
			.cond_i(flag_cond[gi]),
			.mask_i(flag_mask[gi]),
			.mode_i(ctir_pkg::ctir_trig_t'(mode_reg[2*gi+1 -: 2])),
			.clear_i(status_clear),
			.flag_o(flags[gi])
		);
	end

	always_comb begin
		status_word = `CTIR_RDATA_IDLE; // [R10]
		status_word[`CTIR_BIT_COPY] = flags[0];
		status_word[`CTIR_BIT_SLIP] = flags[1];
		status_word[`CTIR_BIT_READY] = flags[2];
		status_word[`CTIR_BIT_RATIO] = flags[3];
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			irq_n_reg <= 1'b1;
			tx_summary_reg <= 1'b0;
			conv_summary_reg <= 1'b0;
		end else begin
			irq_n_reg <= ~(|flags); // [R02] [R07]
			tx_summary_reg <= flags[0] | flags[1]; // [R02]
			conv_summary_reg <= flags[2] | flags[3]; // [R07]
		end
	end

	assign irq_n_o = irq_n_reg;
	assign tx_summary_o = tx_summary_reg;
	assign conv_summary_o = conv_summary_reg;
	// read data one cycle after the strobe; unmapped reads give zero
	always_comb begin
		case (reg_addr_i)
			`CTIR_ADDR_STATUS: rdata_next = status_word; // [R10]
			`CTIR_ADDR_MASK: rdata_next = mask_reg;
			`CTIR_ADDR_MODE: rdata_next = mode_reg;
			`CTIR_ADDR_RX_ONE: rdata_next = rx_one_reg;
			`CTIR_ADDR_RX_TWO: rdata_next = rx_two_reg;
			default: rdata_next = `CTIR_RDATA_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			reg_rdata_reg <= `CTIR_RDATA_IDLE;
			reg_rvalid_reg <= 1'b0;
		end else begin
			reg_rvalid_reg <= reg_rd_i;
			if (reg_rd_i) begin
				reg_rdata_reg <= rdata_next;
			end
		end
	end

	assign reg_rdata_o = reg_rdata_reg;
	assign reg_rvalid_o = reg_rvalid_reg;
	// receiver input and reference routing, retimed so outputs come from flops
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rx_core_reg <= 1'b0;
			first_ref_reg <= 1'b0;
		end else begin
			rx_core_reg <= s_line_rx[rx_one_reg[`CTIR_RX_ONE_SEL_MSB:`CTIR_RX_ONE_SEL_LSB]]; // [R11]
			first_ref_reg <= rx_one_reg[`CTIR_RX_ONE_REF_BIT] ? s_master_clk : s_ref_input; // [R12]
		end
	end

	assign rx_core_data_o = rx_core_reg;
	assign receiver_first_loop_ref_o = first_ref_reg;
	assign receiver_copy_enable_o = ~rx_one_reg[`CTIR_RX_ONE_COPYDIS_BIT]; // [R13]
	// divider counts sampled rising edges; limited to loop clocks well below clk_sys/2
	assign clk_stopped = s_loop_lost & ~rx_two_reg[`CTIR_RX_TWO_LOL_BIT]; // [R17]
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			loop_clk_prev_reg <= 1'b0;
			div_cnt_reg <= 3'h0;
		end else begin
			loop_clk_prev_reg <= s_loop_clk;
			if (!clk_stopped && s_loop_clk && !loop_clk_prev_reg) begin
				div_cnt_reg <= div_cnt_reg + 3'h1; // [R15]
			end
		end
	end

	always_comb begin
		case (rx_two_reg[`CTIR_RX_TWO_DIV_MSB:`CTIR_RX_TWO_DIV_LSB])
			2'h0: div_clk = s_loop_clk; // [R15]
			2'h1: div_clk = div_cnt_reg[0];
			2'h2: div_clk = div_cnt_reg[1];
			default: div_clk = div_cnt_reg[2];
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rec_clk_reg <= 1'b0;
			rec_clk_oe_reg <= 1'b0;
		end else begin
			rec_clk_reg <= clk_stopped ? 1'b0 : div_clk; // [R17]
			rec_clk_oe_reg <= rx_two_reg[`CTIR_RX_TWO_OE_BIT]; // [R14]
		end
	end
	assign recovered_clock_int_o = rec_clk_reg; // [R15]
	assign recovered_clock_o = rec_clk_reg & rec_clk_oe_reg; // [R14]
	assign recovered_clock_oe_o = rec_clk_oe_reg; // [R14]
	// audio arrives on clk_sys from the decoder, so no synchroniser on it
	assign both_lost = s_dec_lost & s_loop_lost;
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			audio_reg <= '0;
		end else if (rx_two_reg[`CTIR_RX_TWO_MUTE_BIT] && both_lost) begin
			audio_reg <= '0; // [R16]
		end else begin
			audio_reg <= audio_data_i;
		end
	end

	assign audio_data_o = audio_reg;
	property p_status_zero_bits;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		status_clear |=> (reg_rvalid_o && reg_rdata_o[7:6] == 2'h0 && reg_rdata_o[3:2] == 2'h0);
	endproperty
	a_status_zero_bits: assert property (p_status_zero_bits) else $error("status bits leak"); // [R10]
	property p_status_ro;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		(reg_wr_i && reg_addr_i == `CTIR_ADDR_STATUS) |=> $stable(mask_reg) && $stable(mode_reg);
	endproperty
	a_status_ro: assert property (p_status_ro) else $error("status write changed state"); // [R10]
	property p_irq_tx;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		(flags[0] || flags[1]) |=> (!irq_n_o && tx_summary_o);
	endproperty
	a_irq_tx: assert property (p_irq_tx) else $error("tx flag without interrupt"); // [R02]
	property p_irq_conv;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		(flags[2] || flags[3]) |=> (!irq_n_o && conv_summary_o);
	endproperty
	a_irq_conv: assert property (p_irq_conv) else $error("conv flag without interrupt"); // [R07]
	property p_irq_idle;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		(flags == 4'h0) |=> (irq_n_o && !tx_summary_o && !conv_summary_o);
	endproperty
	a_irq_idle: assert property (p_irq_idle) else $error("interrupt without flag"); // [R02]
	property p_copy_blocked;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		(tx_copy_disable_i && !flags[0]) |=> !flags[0];
	endproperty
	a_copy_blocked: assert property (p_copy_blocked) else $error("copy flag while blocked"); // [R01]
	property p_mute;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		(rx_two_reg[`CTIR_RX_TWO_MUTE_BIT] && both_lost) |=> (audio_data_o == '0);
	endproperty
	a_mute: assert property (p_mute) else $error("audio not muted"); // [R16]
	property p_input_select;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		1'b1 |=> (rx_core_data_o ==
			$past(s_line_rx[rx_one_reg[`CTIR_RX_ONE_SEL_MSB:`CTIR_RX_ONE_SEL_LSB]]));
	endproperty
	a_input_select: assert property (p_input_select) else $error("wrong line receiver"); // [R11]
	property p_pin_float;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		!rx_two_reg[`CTIR_RX_TWO_OE_BIT] |=> (!recovered_clock_oe_o && !recovered_clock_o);
	endproperty
	a_pin_float: assert property (p_pin_float) else $error("recovered pin driven"); // [R14]
	property p_clock_stop;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		clk_stopped [*2] |=> (!recovered_clock_int_o && $stable(div_cnt_reg));
	endproperty
	a_clock_stop: assert property (p_clock_stop) else $error("clock ran on lock loss"); // [R17]
endmodule

/* File: hw/ctir_params.svh */
// named offsets, bit positions, reset values for the converter/transmitter flag block
// assumes inclusion by bare name from the design files
`ifndef CTIR_PARAMS_SVH
`define CTIR_PARAMS_SVH

`define CTIR_ADDR_STATUS 8'h0A
`define CTIR_ADDR_MASK 8'h0B
`define CTIR_ADDR_MODE 8'h0C
`define CTIR_ADDR_RX_ONE 8'h0D
`define CTIR_ADDR_RX_TWO 8'h0E

`define CTIR_BIT_COPY 0
`define CTIR_BIT_SLIP 1
`define CTIR_BIT_READY 4
`define CTIR_BIT_RATIO 5

`define CTIR_MASK_WMASK 8'h33
`define CTIR_RX_ONE_WMASK 8'h1B
`define CTIR_RX_TWO_WMASK 8'h1F

`define CTIR_RST_MASK 8'h00
`define CTIR_RST_MODE 8'h00
`define CTIR_RST_RX_ONE 8'h00
`define CTIR_RST_RX_TWO 8'h00
`define CTIR_RDATA_IDLE 8'h00

`define CTIR_RX_ONE_SEL_LSB 0
`define CTIR_RX_ONE_SEL_MSB 1
`define CTIR_RX_ONE_REF_BIT 3
`define CTIR_RX_ONE_COPYDIS_BIT 4

`define CTIR_RX_TWO_OE_BIT 0
`define CTIR_RX_TWO_DIV_LSB 1
`define CTIR_RX_TWO_DIV_MSB 2
`define CTIR_RX_TWO_MUTE_BIT 3
`define CTIR_RX_TWO_LOL_BIT 4

`define CTIR_SYNC_W 14

`endif

/* File: hw/ctir_pkg.sv */
// types shared by the flag cell and the register block
// assumes the params header is included where numbers are needed
package ctir_pkg;

	typedef enum logic [1:0] {
		CTIR_TRIG_RISE,
		CTIR_TRIG_FALL,
		CTIR_TRIG_LEVEL,
		CTIR_TRIG_RSVD
	} ctir_trig_t;

	typedef struct packed {
		logic tx_copy_done;
		logic tx_data_slip;
		logic tx_block_start;
		logic conv_ready;
		logic conv_ratio;
	} ctir_cond_t;

	typedef struct packed {
		logic decoder_lock_loss;
		logic second_loop_lock_loss;
	} ctir_lock_t;

endpackage

/* File: hw/ctir_flag_cell.sv */
// one sticky or level-following status flag with mask and trigger mode
// assumes cond_i is already synchronous to clk_sys_i
`timescale 1ns/1ps
module ctir_flag_cell (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic cond_i,
	input wire logic mask_i,
	input wire ctir_pkg::ctir_trig_t mode_i,
	input wire logic clear_i,
	output logic flag_o
);
	logic cond_prev_reg;
	logic flag_reg;
	logic set_event;
	logic flag_next;

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cond_prev_reg <= 1'b0;
		end else begin
			cond_prev_reg <= cond_i;
		end
	end

	always_comb begin
		case (mode_i)
			ctir_pkg::CTIR_TRIG_RISE: set_event = cond_i & ~cond_prev_reg; // [R09] [R19]
			ctir_pkg::CTIR_TRIG_FALL: set_event = ~cond_i & cond_prev_reg; // [R09] [R19]
			ctir_pkg::CTIR_TRIG_LEVEL: set_event = cond_i; // [R09]
			// reserved code raises nothing, so a stray write cannot storm the pin
			default: set_event = 1'b0;
		endcase
	end

	always_comb begin
		if (!mask_i) begin
			flag_next = 1'b0; // [R08]
		end else if (mode_i == ctir_pkg::CTIR_TRIG_LEVEL) begin
			flag_next = cond_i; // [R19]
		end else if (set_event) begin
			flag_next = 1'b1; // set beats a same-cycle read clear [R19]
		end else if (clear_i) begin
			flag_next = 1'b0; // [R19]
		end else begin
			flag_next = flag_reg;
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			flag_reg <= 1'b0;
		end else begin
			flag_reg <= flag_next;
		end
	end

	assign flag_o = flag_reg;

	property p_cell_masked;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		!mask_i |=> !flag_o;
	endproperty
	a_cell_masked: assert property (p_cell_masked) else $error("masked flag rose"); // [R08]

	property p_cell_clear;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		(clear_i && !set_event && mode_i != ctir_pkg::CTIR_TRIG_LEVEL) |=> !flag_o;
	endproperty
	a_cell_clear: assert property (p_cell_clear) else $error("flag kept after read"); // [R19]

	property p_cell_rise;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		(mask_i && mode_i == ctir_pkg::CTIR_TRIG_RISE && $rose(cond_i)) |=> flag_o;
	endproperty
	a_cell_rise: assert property (p_cell_rise) else $error("rising edge not latched"); // [R19]

	property p_cell_level;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		(mask_i && mode_i == ctir_pkg::CTIR_TRIG_LEVEL) |=> (flag_o == $past(cond_i));
	endproperty
	a_cell_level: assert property (p_cell_level) else $error("level flag off"); // [R19]
endmodule

/* File: test/ctir_host_model.sv */
// host side of the register strobe port: single-byte writes and reads
// assumes the bench clock; requests change 1 ns after a rising edge
`timescale 1ns/1ps
module ctir_host_model (
	input wire logic clk_sys_i,
	input wire logic [7:0] reg_rdata_i,
	input wire logic reg_rvalid_i,
	output logic [7:0] reg_addr_o,
	output logic reg_wr_o,
	output logic reg_rd_o,
	output logic [7:0] reg_wdata_o
);
	initial begin
		reg_addr_o = 8'h00;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_wdata_o = 8'h00;
	end
	// callers never hand over the reserved trigger code
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		#1;
		reg_addr_o = a;
		reg_wdata_o = d;
		reg_wr_o = 1'b1;
		@(posedge clk_sys_i);
		#1;
		reg_wr_o = 1'b0;
		// released lines show a changed value, not the last one
		reg_addr_o = ~a;
		reg_wdata_o = ~d;
	endtask
	// answer stands one cycle after the strobe edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(posedge clk_sys_i);
		#1;
		reg_addr_o = a;
		reg_rd_o = 1'b1;
		@(posedge clk_sys_i);
		#1;
		reg_rd_o = 1'b0;
		reg_addr_o = ~a;
		d = reg_rdata_i;
		v = reg_rvalid_i;
	endtask
endmodule

/* File: test/testbench.sv */
// self-checking bench for the flag and receiver control registers
// assumes the host model as register master and default AUDIO_W
`timescale 1ns/1ps
module testbench;
	logic clk_sys_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [7:0] addr, wdata, rdata;
	logic wr, rd, rvalid;
	ctir_pkg::ctir_cond_t cond = '0;
	ctir_pkg::ctir_lock_t lock = '0;
	logic tx_dis = 1'b0, slip_sel = 1'b0, ref_in = 1'b0, mclk = 1'b0;
	logic [3:0] line_rx = 4'h0;
	logic [7:0] sl_cnt = 8'h00;
	logic [23:0] aud_in = 24'hA5A5A5;
	logic tx_en, irq_n, tx_sum, cv_sum, rx_core, ref_out, rx_cen, rck, rck_oe, rck_int;
	logic [23:0] aud_out;
	int err_count = 0, compares = 0, cyc = 0;
	always #4 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) sl_cnt <= #1 sl_cnt + 8'h01;
	ctir_host_model host (.clk_sys_i(clk_sys_i), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid),
		.reg_addr_o(addr), .reg_wr_o(wr), .reg_rd_o(rd), .reg_wdata_o(wdata));
	ctir_regs uut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .reg_addr_i(addr),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
		.reg_rvalid_o(rvalid), .cond_i(cond), .tx_copy_disable_i(tx_dis),
		.slip_source_select_i(slip_sel), .tx_copy_enable_o(tx_en), .irq_n_o(irq_n),
		.tx_summary_o(tx_sum), .conv_summary_o(cv_sum), .line_rx_i(line_rx),
		.rx_core_data_o(rx_core), .receiver_reference_input_i(ref_in), .master_clock_i(mclk),
		.receiver_first_loop_ref_o(ref_out), .receiver_copy_enable_o(rx_cen),
		.second_loop_clk_i(sl_cnt[2]), .lock_i(lock), .recovered_clock_o(rck),
		.recovered_clock_oe_o(rck_oe), .recovered_clock_int_o(rck_int),
		.audio_data_i(aud_in), .audio_data_o(aud_out));
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic v;
		host.rd(a, d, v);
		chk("rvalid", 32'(v), 32'h1);
		chk("rdata", 32'(d), 32'(e));
	endtask
	task automatic rise_cnt(input int e, input int ep);
		int n;
		int np;
		logic p;
		logic pp;
		n = 0;
		np = 0;
		p = rck_int;
		pp = rck;
		repeat (128) begin
			@(posedge clk_sys_i);
			#1;
			if (rck_int === 1'b1 && p !== 1'b1) n++;
			if (rck === 1'b1 && pp !== 1'b1) np++;
			p = rck_int;
			pp = rck;
		end
		chk("divided clock rises", 32'(n), 32'(e));
		chk("pin clock rises", 32'(np), 32'(ep));
	endtask
	// one flag through one trigger mode; c is the condition bit, b the status bit
	task automatic flag(input int c, input int b, input logic [1:0] m);
		logic [7:0] bit_v;
		logic [7:0] dd;
		logic dv;
		bit_v = 8'h01 << b;
		host.wr(8'h0C, 8'(m) << (b < 2 ? 2 * b : 2 * b - 4));
		host.wr(8'h0B, bit_v);
		cond[c] = (m == 2'b01);
		wt(8);
		host.rd(8'h0A, dd, dv);
		cond[c] = (m != 2'b01);
		wt(8);
		chk("irq_n", 32'(irq_n), 32'h0);
		chk("summary", 32'(b < 2 ? tx_sum : cv_sum), 32'h1);
		rchk(8'h0A, bit_v);
		rchk(8'h0A, m == 2'b10 ? bit_v : 8'h00);
		cond[c] = 1'b0;
		wt(8);
		rchk(8'h0A, 8'h00);
		wt(3);
		chk("irq_n idle", 32'(irq_n), 32'h1);
	endtask
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_count++;
			end_of_test();
		end
	end
	int ci[4] = '{4, 3, 1, 0};
	int sb[4] = '{0, 1, 4, 5};
	initial begin
		wt(3);
		resetn_i = 1'b1;
		chk("irq_n reset", 32'(irq_n), 32'h1);
		chk("rx copy enable", 32'(rx_cen), 32'h1);
		chk("pin enable", 32'(rck_oe), 32'h0);
		chk("tx copy enable", 32'(tx_en), 32'h1);
		for (int a = 8'h0B; a <= 8'h0E; a++) rchk(8'(a), 8'h00);
		host.wr(8'h0B, 8'hFF);
		rchk(8'h0B, 8'h33);
		host.wr(8'h0C, 8'hAA);
		rchk(8'h0C, 8'hAA);
		host.wr(8'h0A, 8'hFF);
		rchk(8'h0A, 8'h00);
		rchk(8'h0F, 8'h00);
		host.wr(8'h0B, 8'h00);
		for (int i = 0; i < 4; i++)
			for (int m = 0; m < 3; m++) flag(ci[i], sb[i], 2'(m));
		// masked flag stays clear
		host.wr(8'h0C, 8'h00);
		host.wr(8'h0B, 8'h00);
		cond.conv_ratio = 1'b1;
		wt(8);
		rchk(8'h0A, 8'h00);
		// copy blocked while disabled
		tx_dis = 1'b1;
		host.wr(8'h0B, 8'h33);
		rchk(8'h0A, 8'h00);
		cond.tx_copy_done = 1'b1;
		wt(8);
		chk("tx copy enable", 32'(tx_en), 32'h0);
		rchk(8'h0A, 8'h00);
		cond = '0;
		// slip source follows select
		slip_sel = 1'b1;
		cond.tx_data_slip = 1'b1;
		wt(8);
		rchk(8'h0A, 8'h00);
		cond.tx_block_start = 1'b1;
		wt(8);
		rchk(8'h0A, 8'h02);
		for (int s = 0; s < 4; s++) begin
			host.wr(8'h0D, 8'(s));
			line_rx = 4'h1 << s;
			wt(5);
			chk("rx core", 32'(rx_core), 32'h1);
			line_rx = ~(4'h1 << s);
			wt(5);
			chk("rx core", 32'(rx_core), 32'h0);
		end
		mclk = 1'b1;
		host.wr(8'h0D, 8'h18);
		wt(5);
		chk("first loop ref", 32'(ref_out), 32'h1);
		chk("rx copy enable", 32'(rx_cen), 32'h0);
		host.wr(8'h0D, 8'h00);
		wt(5);
		chk("first loop ref", 32'(ref_out), 32'h0);
		for (int d = 0; d < 4; d++) begin
			host.wr(8'h0E, 8'(2 * d + 1));
			wt(4);
			chk("pin enable", 32'(rck_oe), 32'h1);
			rise_cnt(16 >> d, 16 >> d);
		end
		host.wr(8'h0E, 8'h08);
		wt(3);
		chk("pin level", 32'(rck), 32'h0);
		chk("pin enable", 32'(rck_oe), 32'h0);
		lock = 2'b11;
		wt(6);
		chk("muted audio", 32'(aud_out), 32'h0);
		rise_cnt(0, 0);
		host.wr(8'h0E, 8'h10);
		wt(6);
		chk("unmuted audio", 32'(aud_out), 32'hA5A5A5);
		rise_cnt(16, 0);
		end_of_test();
	end
endmodule
